// [design/tws_eeprom_slave.v]
// Overview of operation
// RULE1 - Byte-wide array sized by capacity variant
// RULE2 - 2K: eight-byte pages, 8-bit address
// RULE3 - 4K: sixteen-byte pages, 9-bit address
// RULE4 - 8K: sixteen-byte pages, 10-bit address
// RULE5 - 16K: sixteen-byte pages, 11-bit address
// RULE6 - 2K compares all three chip pins
// RULE7 - 4K compares two upper chip pins
// RULE8 - 8K compares only highest chip pin
// RULE9 - 16K ignores every chip pin
// RULE10 - Write protect high blocks all writes
// RULE11 - Write protect low allows normal access
// RULE12 - Sample on rise, change after fall
// RULE13 - Data line only pulled low or released
// RULE14 - Data changes only while clock low
// RULE15 - Start condition begins a new transaction
// RULE16 - Stop after read enters standby
// RULE17 - Acknowledge each received byte on ninth clock
// RULE18 - Standby at power-up and after stop
// RULE19 - Master recovers with nine clocks, start
// RULE20 - Page writes, partial pages accepted
// RULE21 - Self-timed write cycle within 5 ms
// RULE22 - Selection word starts with 1010 pattern
// RULE23 - Last selection bit chooses read or write
// RULE24 - Page bits form address high bits
// RULE25 - Page write wraps low address bits
// RULE26 - Busy device ignores bus, no acknowledge
`timescale 1ns/10ps
`include "tws_defines.vh"

module tws_eeprom_slave #(
	parameter [1:0] VARIANT = 2'h3,
	parameter TWR_CYCLES = `TWS_TWR_CYCLES
) (
	input wire clk,
	input wire resetn,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire chip_addr_pin_low,
	input wire chip_addr_pin_mid,
	input wire chip_addr_pin_high,
	input wire write_protect,
	output reg standby_q,
	output reg busy_q
);

	// Phases of a transaction
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_SEL = 3'h1;
	localparam [2:0] ST_WADDR = 3'h2;
	localparam [2:0] ST_WDATA = 3'h3;
	localparam [2:0] ST_RDATA = 3'h4;
	localparam [2:0] ST_RACK = 3'h5;

	// Last count of the write cycle, cut to the counter width on purpose
	localparam [31:0] TWR_FULL = TWR_CYCLES - 1;
	localparam [22:0] TWR_LAST = TWR_FULL[22:0];

	// Variant-dependent geometry: low address bits and used address mask
	wire [3:0] page_mask = (VARIANT == 2'h0) ? 4'h7 : 4'hf; // RULE2 RULE3 RULE4 RULE5
	wire [10:0] addr_mask = (VARIANT == 2'h0) ? 11'h0ff : (VARIANT == 2'h1) ? 11'h1ff :
		(VARIANT == 2'h2) ? 11'h3ff : 11'h7ff; // RULE1

	reg [`TWS_BYTE_W-1:0] mem [0:`TWS_MEM_BYTES-1]; // RULE1
	reg [`TWS_BYTE_W-1:0] page_buf [0:`TWS_PAGE_MAX-1];

	// Two-flop synchronisers for the bus pins, plus a history stage for edges
	reg scl_s1_q, scl_s2_q, scl_s3_q;
	reg sda_s1_q, sda_s2_q, sda_s3_q;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end
		else
		begin
			scl_s1_q <= scl_in;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_in;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	// Edge and condition detection; data moving with clock high is a condition
	wire scl_rise = scl_s2_q & ~scl_s3_q;
	wire scl_fall = ~scl_s2_q & scl_s3_q;
	wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q; // RULE14 RULE15
	wire stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q; // RULE14 RULE16

	// Straps and write protect are pins too; reset comes up protected
	reg [3:0] strap_s1_q, strap_s2_q;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			strap_s1_q <= `TWS_STRAP_RST;
			strap_s2_q <= `TWS_STRAP_RST;
		end
		else
		begin
			strap_s1_q <= {write_protect, chip_addr_pin_high,
				chip_addr_pin_mid, chip_addr_pin_low};
			strap_s2_q <= strap_s1_q;
		end
	end
	wire wp_sync = strap_s2_q[3];

	// Selection compare over the chip pins each variant uses
	wire [2:0] pins = strap_s2_q[2:0];
	wire [2:0] pin_use = (VARIANT == 2'h0) ? 3'h7 : (VARIANT == 2'h1) ? 3'h6 :
		(VARIANT == 2'h2) ? 3'h4 : 3'h0; // RULE6 RULE7 RULE8 RULE9

	reg [2:0] state_q;
	reg [3:0] bitcnt_q;
	reg [7:0] shift_q;
	reg [10:0] addr_q;
	reg [2:0] pagebits_q;
	reg rd_q;
	reg [4:0] wcount_q;
	reg [10:0] wbase_q;
	reg commit_q;
	reg [22:0] twr_q;
	reg [4:0] cp_q;
	reg pending_q;

	wire [7:0] rx_byte = {shift_q[6:0], sda_s2_q};
	// Judged at the eighth falling clock, when the shifter holds the whole word
	wire sel_match = (shift_q[7:4] == `TWS_SEL_PATTERN) &&
		(((shift_q[3:1] ^ pins) & pin_use) == 3'h0); // RULE22
	wire [10:0] sel_hi = {pagebits_q, 8'h00} & addr_mask; // RULE24
	wire [10:0] rd_next = (addr_q + 11'h001) & addr_mask;
	// Final cycle of the timed write
	wire twr_done = (twr_q >= TWR_LAST);

	// Bus protocol engine: bits in on rising clock, line changes after falling clock
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= ST_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			addr_q <= `TWS_ADDR_RST;
			pagebits_q <= 3'h0;
			rd_q <= 1'b0;
			wcount_q <= 5'h00;
			wbase_q <= `TWS_ADDR_RST;
			commit_q <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			standby_q <= 1'b1; // RULE18
		end
		else
		begin
			commit_q <= 1'b0;
			if (busy_q)
			begin
				// Inputs are deaf during the write cycle
				state_q <= ST_IDLE; // RULE26
				sda_oe <= 1'b0; // RULE26
				if (twr_done)
					standby_q <= 1'b1; // RULE18
			end
			else if (start_det)
			begin
				state_q <= ST_SEL; // RULE15
				bitcnt_q <= 4'h0;
				sda_oe <= 1'b0;
				standby_q <= 1'b0;
			end
			else if (stop_det)
			begin
				// A finished unprotected write enters the timed cycle; otherwise standby
				if (state_q == ST_WDATA && !rd_q && wcount_q != 5'h00 && !wp_sync)
					commit_q <= 1'b1; // RULE10 RULE11
				else
					standby_q <= 1'b1; // RULE16 RULE18
				state_q <= ST_IDLE;
				sda_oe <= 1'b0;
			end
			else if (scl_rise && state_q != ST_IDLE)
			begin
				if (bitcnt_q == `TWS_ACK_BIT)
				begin
					// Ninth clock: master acknowledge matters only in reads
					if (state_q == ST_RACK && sda_s2_q)
						state_q <= ST_IDLE;
				end
				else if (state_q != ST_RDATA)
					shift_q <= rx_byte; // RULE12
				bitcnt_q <= (bitcnt_q == `TWS_ACK_BIT) ? 4'h0 : bitcnt_q + 4'h1;
			end
			else if (scl_fall && state_q != ST_IDLE)
			begin
				if (bitcnt_q == `TWS_ACK_BIT)
				begin
					// Byte complete: decide acknowledge and next phase
					sda_out <= 1'b0; // RULE13
					case (state_q)
						ST_SEL:
						begin
							if (sel_match)
							begin
								sda_oe <= 1'b1; // RULE17
								pagebits_q <= shift_q[3:1];
								rd_q <= shift_q[`TWS_SEL_RW_BIT]; // RULE23
								state_q <= shift_q[0] ? ST_RDATA : ST_WADDR;
								wcount_q <= 5'h00;
							end
							else
							begin
								state_q <= ST_IDLE;
								standby_q <= 1'b1;
							end
						end
						ST_WADDR:
						begin
							sda_oe <= 1'b1; // RULE17
							addr_q <= (sel_hi | {3'h0, shift_q}) & addr_mask; // RULE24
							wbase_q <= (sel_hi | {3'h0, shift_q}) & addr_mask;
							state_q <= ST_WDATA;
						end
						ST_WDATA:
						begin
							sda_oe <= 1'b1; // RULE17
							page_buf[addr_q[3:0] & page_mask] <= shift_q; // RULE20
							if (wcount_q <= {1'b0, page_mask})
								wcount_q <= wcount_q + 5'h01;
							addr_q <= (addr_q & ~{7'h00, page_mask}) |
								({7'h00, addr_q[3:0] + 4'h1} & {7'h00, page_mask}); // RULE25
						end
						ST_RDATA:
						begin
							sda_oe <= 1'b0;
							state_q <= ST_RACK;
							addr_q <= rd_next;
						end
						default:
							state_q <= ST_IDLE;
					endcase
				end
				else if (state_q == ST_RDATA || (state_q == ST_RACK && bitcnt_q == 4'h0))
				begin
					// Drive read bit: pull low for zero, release for one
					if (bitcnt_q == 4'h0)
					begin
						state_q <= ST_RDATA;
						shift_q <= {mem[addr_q][6:0], 1'b0};
						sda_oe <= ~mem[addr_q][7]; // RULE12 RULE13
					end
					else
					begin
						shift_q <= {shift_q[6:0], 1'b0};
						sda_oe <= ~shift_q[7]; // RULE13
					end
				end
				else
					sda_oe <= 1'b0;
			end
		end
	end

	// Self-timed write cycle; the buffered page lands at its start, one byte per cycle
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_q <= 1'b0;
			twr_q <= 23'h000000;
			cp_q <= 5'h00;
			pending_q <= 1'b0;
		end
		else if (commit_q)
		begin
			busy_q <= 1'b1; // RULE21
			twr_q <= 23'h000000;
			cp_q <= 5'h00;
			pending_q <= 1'b1;
		end
		else if (busy_q)
		begin
			if (pending_q)
			begin
				// One byte per cycle from the page buffer into the array
				if (cp_q < wcount_q)
					mem[(wbase_q & ~{7'h00, page_mask}) |
						({7'h00, wbase_q[3:0] + cp_q[3:0]} & {7'h00, page_mask})] <=
						page_buf[(wbase_q[3:0] + cp_q[3:0]) & page_mask]; // RULE20
				else
					pending_q <= 1'b0;
				cp_q <= cp_q + 5'h01;
			end
			twr_q <= twr_q + 23'h000001;
			if (twr_done)
				busy_q <= 1'b0; // RULE21
		end
	end

endmodule // tws_eeprom_slave

// [design/tws_defines.vh]
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH
// Selection word fixed pattern and its field positions
`define TWS_SEL_PATTERN 4'ha
`define TWS_SEL_RW_BIT 0
// Array size at the largest variant
`define TWS_MEM_BYTES 2048
`define TWS_ADDR_W 11
// Byte width and bit counter terminal value
`define TWS_BYTE_W 8
`define TWS_ACK_BIT 4'h8
// Page buffer size and write cycle time
`define TWS_PAGE_MAX 16
`define TWS_TWR_NS 5000000
`define TWS_CLK_NS 10
`define TWS_TWR_CYCLES (`TWS_TWR_NS / `TWS_CLK_NS)
// Reset values
`define TWS_ADDR_RST 11'h000
`define TWS_STRAP_RST 4'h8
`endif

// [sim/tws_properties.sv]
`timescale 1ns/10ps
module tws_props #(parameter TWR_CYCLES = 200) (
	input wire clk,
	input wire resetn,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire standby_q,
	input wire busy_q
);
	int cnt_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Age of the write cycle, to bound its length
	always @(posedge clk or negedge resetn)
		if (!resetn)
			cnt_q <= 0;
		else
			cnt_q <= busy_q ? cnt_q + 1 : 0;
	a_never_high: assert property (sda_out == 1'b0) else $error("data driven high");
	a_oe_clk_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("data moved with clock high");
	a_busy_no_ack: assert property (busy_q |-> !sda_oe) else $error("drive while busy");
	a_busy_bound: assert property (busy_q |-> cnt_q < TWR_CYCLES + 3)
		else $error("write cycle too long");
	a_busy_awake: assert property (busy_q |-> !standby_q) else $error("standby while busy");
	a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe[*8])
		else $error("low drive too short");
	a_reset_state: assert property ($rose(resetn) |-> standby_q && !busy_q && !sda_oe)
		else $error("bad reset state");
	a_busy_on_stop: assert property ($rose(busy_q) |-> scl_in && sda_in)
		else $error("write cycle without stop");
	// Main scenarios seen
	cover property ($rose(busy_q));
	cover property ($fell(sda_oe));
	cover property ($rose(standby_q));
endmodule // tws_props

// [sim/tws_master.sv]
`timescale 1ns/10ps
module tws_master (
	input wire clk,
	input wire sda,
	output logic scl,
	output logic sda_low
);
	// Bus idles released, clock high
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Quarter of the 160 ns bus period, moves at falling clk
	task q;
		repeat (4) @(negedge clk);
	endtask
	// Data moves only with the clock low
	task bitx(input logic b, output logic r);
		sda_low = ~b;
		q;
		scl = 1'b1;
		q;
		r = sda;
		q;
		scl = 1'b0;
		q;
	endtask
	// Data falls with clock high
	task start;
		sda_low = 1'b0;
		q;
		scl = 1'b1;
		q;
		sda_low = 1'b1;
		q;
		scl = 1'b0;
		q;
	endtask
	// Data rises with clock high
	task stop;
		sda_low = 1'b1;
		q;
		scl = 1'b1;
		q;
		sda_low = 1'b0;
		q;
	endtask
	// Nine bits, MSB first, last one the acknowledge slot
	task xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
			bitx(d[i], r[i]);
	endtask
	// Clock out a stuck target, then start afresh
	task recover;
		logic r;
		for (int i = 0; i < 9 && sda !== 1'b1; i++)
			bitx(1'b1, r);
		start;
	endtask
endmodule // tws_master

// [sim/tb_top.sv]
`timescale 1ns/10ps
bind tws_eeprom_slave tws_props #(.TWR_CYCLES(TWR_CYCLES)) u_props (.clk(clk),
	.resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .standby_q(standby_q), .busy_q(busy_q));
module tb_top;
	localparam TWR_CYCLES = 200;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wp = 1'b0;
	logic [2:0] pins = 3'h0;
	logic scl, sda_low, sda_oe, sda_out, standby_q, busy_q;
	logic [8:0] r, base;
	logic [7:0] pg [0:15];
	int errors = 0;
	int cmp_count = 0;
	int k;
	wire sda = ~(sda_low | sda_oe); // Pull-up wins when nobody pulls low
	initial
		forever #5 clk = ~clk;
	tws_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	tws_eeprom_slave #(.VARIANT(2'h1), .TWR_CYCLES(TWR_CYCLES)) DUT (.clk(clk), .resetn(resetn),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.chip_addr_pin_low(pins[0]), .chip_addr_pin_mid(pins[1]), .chip_addr_pin_high(pins[2]),
		.write_protect(wp), .standby_q(standby_q), .busy_q(busy_q));
	task check(input logic [8:0] got, input logic [8:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("Comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Pattern, two upper pins, page bit, direction, released ack slot
	function logic [8:0] sel(input logic [1:0] hm, input logic pb, input logic rd);
		return {4'ha, hm, pb, rd, 1'b1};
	endfunction
	// Write position wraps inside a sixteen-byte page
	function logic [3:0] slot(input logic [3:0] o, input int j);
		return o + j[3:0];
	endfunction
	// Select for write, then the address byte
	task hdr(input logic [8:0] a);
		m.start;
		m.xfer(sel(pins[2:1], a[8], 1'b0), r);
		check(r[0], 1'b0);
		m.xfer({a[7:0], 1'b1}, r);
		check(r[0], 1'b0);
	endtask
	// Bounded wait for the write cycle to end
	task wait_idle;
		for (k = 0; k < 1000 && busy_q !== 1'b0; k++)
			@(negedge clk);
		if (k == 1000)
		begin
			errors++;
			close_out;
		end
	endtask
	initial
	begin
		k = $urandom(25301);
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		check(standby_q, 1'b1);
		pins = 3'($urandom);
		base = 9'($urandom);
		// Wrong upper pins: refused
		m.start;
		m.xfer(sel(~pins[2:1], 1'b0, 1'b0), r);
		check(r[0], 1'b1);
		m.stop;
		check(standby_q, 1'b1);
		// Eighteen bytes overwrite the first two; lowest pin wanders, being ignored
		hdr(base);
		for (int j = 0; j < 18; j++)
		begin
			pins[0] = 1'($urandom);
			pg[slot(base[3:0], j)] = 8'($urandom);
			m.xfer({pg[slot(base[3:0], j)], 1'b1}, r);
			check(r[0], 1'b0);
		end
		m.stop;
		check(busy_q, 1'b1);
		m.start;
		m.xfer(sel(pins[2:1], base[8], 1'b0), r);
		check(r[0], 1'b1);
		m.stop;
		wait_idle;
		check(standby_q, 1'b1);
		// Protected write leaves the array alone
		wp = 1'b1;
		hdr(base);
		m.xfer({8'(~pg[base[3:0]]), 1'b1}, r);
		check(r[0], 1'b0);
		m.stop;
		check(busy_q, 1'b0);
		wait_idle;
		wp = 1'b0;
		// Random read of the whole page
		hdr({base[8:4], 4'h0});
		m.start;
		m.xfer(sel(pins[2:1], base[8], 1'b1), r);
		check(r[0], 1'b0);
		for (int j = 0; j < 16; j++)
		begin
			m.xfer({8'hff, j == 15}, r);
			check(r[8:1], pg[j]);
		end
		m.stop;
		check(standby_q, 1'b1);
		// Abort a read mid-byte, recover, and select again
		m.start;
		m.xfer(sel(pins[2:1], base[8], 1'b1), r);
		repeat (3) m.bitx(1'b1, r[0]);
		m.recover;
		m.xfer(sel(pins[2:1], base[8], 1'b0), r);
		check(r[0], 1'b0);
		m.stop;
		check(sda_out, 1'b0);
		close_out;
	end
endmodule // tb_top
